// ===== hdl/gp_timers_pkg.sv
// Constants shared by the general-purpose timer block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package gp_timers_pkg;
   localparam int NUM_TIMERS = 5;
   localparam int ADDR_W = 8;
   // Register map: timer k at base k * 0x10 (address bits 7:4 select the timer)
   localparam logic [3:0] CTL_OFS = 4'h0;
   localparam logic [3:0] COUNT_OFS = 4'h4;
   localparam logic [3:0] PERIOD_OFS = 4'h8;
   localparam logic [7:0] STATUS_ADDR = 8'h50;
   // Control field positions
   localparam int RUN_BIT = 15;
   localparam int IDLE_BIT = 13;
   localparam int GATE_BIT = 6;
   localparam int PRE_HI = 5;
   localparam int PRE_LO = 4;
   localparam int JOIN_BIT = 3;
   localparam int SYNC_BIT = 2;
   localparam int SRC_BIT = 1;
   // Writable bits per control register type; the rest read as zero
   localparam logic [15:0] MASK_A = 16'ha076;
   localparam logic [15:0] MASK_LOW = 16'ha07a;
   localparam logic [15:0] MASK_HIGH = 16'ha072;
   localparam logic [15:0] MASK_FULL = 16'hffff;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hffff;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
   localparam logic [7:0] PRE_LIM_1 = 8'h00;
   localparam logic [7:0] PRE_LIM_8 = 8'h07;
   localparam logic [7:0] PRE_LIM_64 = 8'h3f;
   localparam logic [7:0] PRE_LIM_256 = 8'hff;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0]
   {
      MODE_TIMER = 2'b00,
      MODE_GATED = 2'b01,
      MODE_SYNC_CNT = 2'b10,
      MODE_ASYNC_CNT = 2'b11
   } mode_type;
endpackage : gp_timers_pkg

// ===== hdl/gp_timers.sv
// Five general-purpose timers: timer A (index 0) and two joinable pairs
// (indices 1/2 and 3/4), with an AXI4-Lite register slave.
// Assumes pins and tick strobes are synchronous to i_clk.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module gp_timers
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // AXI4-Lite write
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [gp_timers_pkg::ADDR_W-1:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // AXI4-Lite read
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [gp_timers_pkg::ADDR_W-1:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   // Device clocks, power state and pins
   input wire logic i_instruction_cycle_clock,
   input wire logic i_peripheral_clock,
   input wire logic i_idle,
   input wire logic i_timer_a_ext_clock_pin,
   input wire logic [3:0] i_pair_ext_clock_pin,
   // Events
   output logic [gp_timers_pkg::NUM_TIMERS-1:0] o_flag,
   output logic o_adc_trigger,
   output logic [3:0] o_dma_trigger,
   output logic [1:0] o_time_base_tick,
   output logic [15:0] o_time_base_count0,
   output logic [15:0] o_time_base_count1
);
   import gp_timers_pkg::*;

   logic [15:0] ctl [NUM_TIMERS];
   logic [15:0] cnt [NUM_TIMERS];
   logic [15:0] per [NUM_TIMERS];
   logic [7:0] pre [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] pin, pin_prev, pin_rise, pin_fall;
   logic [NUM_TIMERS-1:0] run_ok, pre_hit, pre_hit_q, tick, gate_fall;
   logic [NUM_TIMERS-1:0] adv, clr, inc, flag_set, match16;
   logic [NUM_TIMERS-1:0] wr_ctl, wr_cnt, wr_per;
   logic [1:0] joined, match32;
   logic wr_go, wr_hit, wr_status, rd_go, rd_hit, sync_run_a;
   logic [31:0] rd_data;
   mode_type mode_a;

   assign pin = {i_pair_ext_clock_pin, i_timer_a_ext_clock_pin};
   assign pin_rise = pin & ~pin_prev;
   assign pin_fall = ~pin & pin_prev;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         pin_prev <= '0;
      else
         pin_prev <= pin;
   end

   // Write channel: address and data are taken together, one at a time
   assign wr_go = i_awvalid & i_wvalid & ~o_bvalid;
   assign o_awready = wr_go;
   assign o_wready = wr_go;
   assign wr_status = wr_go & (i_awaddr == STATUS_ADDR);

   always_comb
   begin
      wr_hit = wr_status;
      for (int k = 0; k < NUM_TIMERS; k++)
      begin
         wr_ctl[k] = wr_go & (i_awaddr[7:4] == 4'(k))
            & (i_awaddr[3:0] == CTL_OFS);
         wr_cnt[k] = wr_go & (i_awaddr[7:4] == 4'(k))
            & (i_awaddr[3:0] == COUNT_OFS);
         wr_per[k] = wr_go & (i_awaddr[7:4] == 4'(k))
            & (i_awaddr[3:0] == PERIOD_OFS);
         wr_hit = wr_hit | wr_ctl[k] | wr_cnt[k] | wr_per[k];
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         o_bvalid <= 1'b1;
         o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_bready)
         o_bvalid <= 1'b0;
   end

   // Read channel
   assign o_arready = ~o_rvalid;
   assign rd_go = i_arvalid & ~o_rvalid;

   always_comb
   begin
      rd_data = '0;
      rd_hit = (i_araddr == STATUS_ADDR);
      if (rd_hit)
         rd_data = {27'h0000000, o_flag};
      for (int k = 0; k < NUM_TIMERS; k++)
      begin
         if (i_araddr[7:4] == 4'(k))
         begin
            if (i_araddr[3:0] == CTL_OFS)
            begin
               rd_data = {16'h0000, ctl[k]};
               rd_hit = 1'b1;
            end
            if (i_araddr[3:0] == COUNT_OFS)
            begin
               rd_data = {16'h0000, cnt[k]};
               rd_hit = 1'b1;
            end
            if (i_araddr[3:0] == PERIOD_OFS)
            begin
               rd_data = {16'h0000, per[k]};
               rd_hit = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_data;
         o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_rready)
         o_rvalid <= 1'b0;
   end

   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (i_wstrb[0])
         v[7:0] = i_wdata[7:0];
      if (i_wstrb[1])
         v[15:8] = i_wdata[15:8];
      return v & mask;
   endfunction : merge16

   // Timer A mode decode; sync is ignored with the internal source
   assign mode_a = ctl[0][SRC_BIT]
      ? (ctl[0][SYNC_BIT] ? MODE_SYNC_CNT : MODE_ASYNC_CNT)
      : (ctl[0][GATE_BIT] ? MODE_GATED : MODE_TIMER);
   assign sync_run_a = (mode_a == MODE_SYNC_CNT) & ctl[0][RUN_BIT];

   // Pair join state and 32-bit period compare
   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_pair
         assign joined[p] = ctl[2*p+1][JOIN_BIT];
         assign match32[p] = match16[2*p+1] & match16[2*p+2];
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < NUM_TIMERS; i++)
      begin : g_tmr
         localparam logic [15:0] MASK = (i == 0) ? MASK_A
            : ((i % 2) == 1) ? MASK_LOW : MASK_HIGH;
         logic src, gate, sync, raw, src_int;
         logic [7:0] lim;

         assign src = ctl[i][SRC_BIT];
         assign gate = ctl[i][GATE_BIT] & ~src;
         // Pair timers always count synchronously
         assign sync = (i == 0) ? ctl[i][SYNC_BIT] : 1'b1;
         assign src_int = (i == 0) ? i_instruction_cycle_clock
            : i_peripheral_clock;
         assign raw = src ? pin_rise[i]
            : src_int & (~gate | pin[i]);
         assign run_ok[i] = ctl[i][RUN_BIT]
            & ~(ctl[i][IDLE_BIT] & i_idle);
         assign gate_fall[i] = gate & pin_fall[i] & run_ok[i];
         assign match16[i] = (cnt[i] == per[i]);

         always_comb
         begin
            unique case (ctl[i][PRE_HI:PRE_LO])
               2'b00: lim = PRE_LIM_1;
               2'b01: lim = PRE_LIM_8;
               2'b10: lim = PRE_LIM_64;
               2'b11: lim = PRE_LIM_256;
            endcase
         end

         assign pre_hit[i] = raw & run_ok[i] & (pre[i] >= lim);
         // The sync stage sits behind the prescaler, so one count lags
         // the pin by a cycle but the prescaler sees every edge
         assign tick[i] = (src & sync) ? (pre_hit_q[i] & run_ok[i])
            : pre_hit[i];

         always_ff @(posedge i_clk)
         begin
            if (i_srst | wr_ctl[i] | ~run_ok[i])
               pre[i] <= '0;
            else if (raw)
               pre[i] <= (pre[i] >= lim) ? 8'h00 : pre[i] + 8'h01;
         end

         always_ff @(posedge i_clk)
         begin
            if (i_srst)
               pre_hit_q[i] <= 1'b0;
            else
               pre_hit_q[i] <= pre_hit[i] & src & sync;
         end

         always_ff @(posedge i_clk)
         begin
            if (i_srst)
            begin
               ctl[i] <= CTL_RESET;
               per[i] <= PERIOD_RESET;
            end
            else
            begin
               if (wr_ctl[i])
                  ctl[i] <= merge16(ctl[i], MASK);
               if (wr_per[i])
                  per[i] <= merge16(per[i], MASK_FULL);
            end
         end

         // Count clock, wrap and increment enable per timer
         if (i == 0)
         begin : g_a
            assign adv[i] = tick[i];
            assign clr[i] = match16[i];
            assign inc[i] = 1'b1;
            assign flag_set[i] = (adv[i] & clr[i]) | gate_fall[i];
         end
         else if ((i % 2) == 1)
         begin : g_lo
            assign adv[i] = tick[i];
            assign clr[i] = joined[i/2] ? match32[i/2] : match16[i];
            assign inc[i] = 1'b1;
            assign flag_set[i] = ~joined[i/2]
               & ((adv[i] & clr[i]) | gate_fall[i]);
         end
         else
         begin : g_hi
            // Joined: low timer's clock, gate and control drive this word
            assign adv[i] = joined[i/2-1] ? tick[i-1] : tick[i];
            assign clr[i] = joined[i/2-1] ? match32[i/2-1] : match16[i];
            assign inc[i] = ~joined[i/2-1] | (cnt[i-1] == COUNT_MAX);
            assign flag_set[i] = joined[i/2-1]
               ? ((adv[i] & clr[i]) | gate_fall[i-1])
               : ((adv[i] & clr[i]) | gate_fall[i]);
         end

         always_ff @(posedge i_clk)
         begin
            if (i_srst)
               cnt[i] <= COUNT_RESET;
            else if (wr_cnt[i] & ~((i == 0) & sync_run_a))
               cnt[i] <= merge16(cnt[i], MASK_FULL);
            else if (adv[i] & clr[i])
               cnt[i] <= COUNT_RESET;
            else if (adv[i] & inc[i])
               cnt[i] <= cnt[i] + 16'h0001;
         end

         // Sticky flag: a new event wins over a clear in the same cycle
         always_ff @(posedge i_clk)
         begin
            if (i_srst)
               o_flag[i] <= 1'b0;
            else if (flag_set[i])
               o_flag[i] <= 1'b1;
            else if (wr_status & i_wstrb[0] & i_wdata[i])
               o_flag[i] <= 1'b0;
         end
      end
   endgenerate

   // Trigger and time-base pulses, one cycle after the count event
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_adc_trigger <= 1'b0;
         o_dma_trigger <= '0;
         o_time_base_tick <= '0;
         o_time_base_count0 <= '0;
         o_time_base_count1 <= '0;
      end
      else
      begin
         o_adc_trigger <= joined[0] ? (adv[2] & clr[2])
            : (adv[1] & clr[1]);
         o_dma_trigger <= flag_set[4:1];
         o_time_base_tick <= adv[2:1];
         o_time_base_count0 <= cnt[1];
         o_time_base_count1 <= cnt[2];
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   property p_wrap_zero;
      adv[0] && clr[0] && !wr_cnt[0] |=> cnt[0] == COUNT_RESET && o_flag[0];
   endproperty
   a_wrap_zero: assert property (p_wrap_zero)
      else $error("timer A did not wrap and flag on period match");

   // A stopped timer makes no tick, so the very next count must match
   property p_stopped_holds;
      !ctl[0][RUN_BIT] && !wr_cnt[0] |=> $stable(cnt[0]);
   endproperty
   a_stopped_holds: assert property (p_stopped_holds)
      else $error("stopped timer A count moved");

   property p_idle_halt;
      ctl[3][IDLE_BIT] && i_idle && !wr_cnt[3] && !joined[1] |=>
         cnt[3] == $past(cnt[3]);
   endproperty
   a_idle_halt: assert property (p_idle_halt)
      else $error("timer counted in idle with idle-stop set");

   property p_sync_write_ignored;
      wr_cnt[0] && sync_run_a && !adv[0] |=> cnt[0] == $past(cnt[0]);
   endproperty
   a_sync_write_ignored: assert property (p_sync_write_ignored)
      else $error("count write taken in sync counter mode");

   property p_joined_low_flag;
      joined[0] && adv[1] && clr[1] |-> flag_set[2] && !flag_set[1];
   endproperty
   a_joined_low_flag: assert property (p_joined_low_flag)
      else $error("joined pair flagged on the low timer");

   property p_carry;
      joined[0] && adv[1] && !clr[1] && cnt[1] == COUNT_MAX && !wr_cnt[2]
         && !wr_cnt[1] |=> cnt[2] == $past(cnt[2]) + 16'h0001
         && cnt[1] == COUNT_RESET;
   endproperty
   a_carry: assert property (p_carry)
      else $error("32-bit carry into the high word missing");

   property p_div_one;
      ctl[0][RUN_BIT] && ctl[0][PRE_HI:PRE_LO] == 2'b00 && !ctl[0][SRC_BIT]
         && !ctl[0][GATE_BIT] && !ctl[0][IDLE_BIT] && i_instruction_cycle_clock
         && !match16[0] && !wr_cnt[0] && !wr_ctl[0] |=>
         cnt[0] == $past(cnt[0]) + 16'h0001;
   endproperty
   a_div_one: assert property (p_div_one)
      else $error("1:1 prescale did not count every clock");

   property p_adc_source;
      o_adc_trigger |-> $past(adv[1] | adv[2]);
   endproperty
   a_adc_source: assert property (p_adc_source)
      else $error("ADC trigger without a first-pair count event");

   property p_gate_ignored;
      ctl[0][SRC_BIT] && !pin_rise[0] |-> !pre_hit[0] && !gate_fall[0];
   endproperty
   a_gate_ignored: assert property (p_gate_ignored)
      else $error("external source counted without a pin edge");

   property p_cov_wrap32;
      joined[0] && adv[1] && match32[0];
   endproperty
   c_cov_wrap32: cover property (p_cov_wrap32);
   c_cov_gate_fall: cover property (gate_fall[0]);
   c_cov_sync_tick: cover property (tick[0] && mode_a == MODE_SYNC_CNT);
endmodule : gp_timers

// ===== test/gp_pins_model.sv
// Model of the external clock and gate pins seen by the timers.
// Assumes pins change just after a rising edge of i_clk.
`timescale 1ns/1ps
module gp_pins_model
(
   // Clock
   input wire logic i_clk,
   // Pins: bit 0 timer A, bits 4:1 pair timers 1..4
   output logic [4:0] o_pin
);
   initial o_pin = 5'h00;
   // Low for two cycles between pulses so every rising edge is distinct
   task automatic pulse(input int idx, input int n, input int hi);
      repeat (n)
      begin
         @(posedge i_clk);
         o_pin[idx] <= 1'b1;
         repeat (hi) @(posedge i_clk);
         o_pin[idx] <= 1'b0;
         @(posedge i_clk);
      end
   endtask : pulse
endmodule : gp_pins_model

// ===== test/general_purpose_timers_test.sv
// Self-checking bench for the general-purpose timer block.
// Assumes the package, the design and the pin model are compiled first.
`timescale 1ns/1ps
module general_purpose_timers_test;
   import gp_timers_pkg::*;
   logic i_clk, i_srst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic [7:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata, q, v, seed;
   logic [3:0] i_wstrb, o_dma_trigger;
   logic i_instruction_cycle_clock, i_peripheral_clock, i_idle;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_adc_trigger;
   logic [1:0] o_bresp, o_rresp, r;
   logic [4:0] o_flag, pin;
   logic [15:0] o_time_base_count0, o_time_base_count1;
   logic [1:0] o_time_base_tick;
   int n_fail, n_checks, n_adc, nt, a0, d0, n_tb;
   int n_dma [4];
   int divs [4] = '{1, 8, 64, 256};
   gp_pins_model pins (.i_clk, .o_pin(pin));
   gp_timers DUT
   (
      .i_clk, .i_srst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
      .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
      .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata,
      .o_rresp, .i_instruction_cycle_clock, .i_peripheral_clock, .i_idle,
      .i_timer_a_ext_clock_pin(pin[0]), .i_pair_ext_clock_pin(pin[4:1]),
      .o_flag, .o_adc_trigger, .o_dma_trigger, .o_time_base_tick,
      .o_time_base_count0, .o_time_base_count1
   );
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      n_adc <= n_adc + int'(o_adc_trigger);
      n_tb <= n_tb + int'(o_time_base_tick[0]);
      for (int j = 0; j < 4; j++)
         n_dma[j] <= n_dma[j] + int'(o_dma_trigger[j]);
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   // One access; starts on a fresh edge so no strobe is assigned twice
   task automatic bus(input bit wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      if (wr)
      begin
         i_awaddr <= a;
         i_wdata <= {16'h0000, d};
         i_awvalid <= 1'b1;
         i_wvalid <= 1'b1;
         i_bready <= 1'b1;
      end
      else
      begin
         i_araddr <= a;
         i_arvalid <= 1'b1;
         i_rready <= 1'b1;
      end
      for (int k = 0; k < 40; k++)
      begin
         @(posedge i_clk);
         if (i_awvalid && o_awready)
            i_awvalid <= 1'b0;
         if (i_wvalid && o_wready)
            i_wvalid <= 1'b0;
         if (i_arvalid && o_arready)
            i_arvalid <= 1'b0;
         if (wr ? (o_bvalid && i_bready) : (o_rvalid && i_rready))
         begin
            q = wr ? 32'h0 : o_rdata;
            r = wr ? o_bresp : o_rresp;
            i_bready <= 1'b0;
            i_rready <= 1'b0;
            return;
         end
      end
      n_fail++;
      report_and_stop();
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
      check(r, RESP_OKAY);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 16'h0000);
      check(q, exp);
   endtask : rd
   // Random strobes on the chosen internal clock for n cycles
   task automatic run(input int n, input bit p);
      nt = 0;
      repeat (n)
      begin
         @(posedge i_clk);
         seed = xs(seed);
         if (p)
            i_peripheral_clock <= seed[0];
         else
            i_instruction_cycle_clock <= seed[0];
         nt += int'(seed[0]);
      end
      @(posedge i_clk);
      i_instruction_cycle_clock <= 1'b0;
      i_peripheral_clock <= 1'b0;
   endtask : run
   initial
   begin
      repeat (60000) @(posedge i_clk);
      n_fail++;
      report_and_stop();
   end
   initial
   begin
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
      {i_awaddr, i_araddr, i_wdata} = 48'h0;
      {i_instruction_cycle_clock, i_peripheral_clock, i_idle} = 3'h0;
      i_wstrb = 4'h3;
      seed = 32'hd3e8;
      i_srst = 1'b1;
      repeat (5) @(posedge i_clk);
      i_srst <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h28, {16'h0000, PERIOD_RESET});
      wr(8'h00, 16'h7fff);
      rd(8'h00, {16'h0000, MASK_A & 16'h7fff});
      wr(8'h10, 16'h7fff);
      rd(8'h10, {16'h0000, MASK_LOW & 16'h7fff});
      bus(1'b1, 8'h54, 16'hffff);
      check(r, RESP_SLVERR);
      bus(1'b0, 8'h54, 16'h0000);
      check(q, 32'h0);
      check(r, RESP_SLVERR);
      wr(8'h10, 16'h0000);
      $display("register test done");
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h50, 16'h001f);
         wr(8'h00, 16'h0000);
         wr(8'h04, 16'h0000);
         wr(8'h08, c == 0 ? 16'h0004 : 16'hffff);
         wr(8'h00, 16'h8000 | 16'(c << 4));
         run(c == 0 ? 20 : 600, 1'b0);
         a0 = c == 0 ? 5 : 65536;
         rd(8'h04, 32'((nt / divs[c]) % a0));
         rd(8'h50, 32'(nt / divs[c] >= a0));
      end
      $display("prescale test done");
      for (int s = 0; s < 2; s++)
      begin
         wr(8'h00, 16'h0000);
         wr(8'h04, 16'h0000);
         wr(8'h00, s ? 16'ha000 : 16'h8000);
         i_idle <= 1'b1;
         run(40, 1'b0);
         i_idle <= 1'b0;
         rd(8'h04, s ? 32'h0 : 32'(nt));
      end
      wr(8'h00, 16'h0000);
      wr(8'h04, 16'h0000);
      wr(8'h50, 16'h001f);
      wr(8'h00, 16'h8040);
      i_instruction_cycle_clock <= 1'b1;
      pins.pulse(0, 2, 5);
      repeat (3) @(posedge i_clk);
      i_instruction_cycle_clock <= 1'b0;
      rd(8'h04, 32'd10);
      rd(8'h50, 32'h1);
      wr(8'h00, 16'h0000);
      wr(8'h04, 16'h0000);
      wr(8'h00, 16'h8006);
      wr(8'h04, 16'h1234);
      rd(8'h04, 32'h0);
      pins.pulse(0, 3, 2);
      repeat (3) @(posedge i_clk);
      rd(8'h04, 32'd3);
      wr(8'h00, 16'h8042);
      wr(8'h04, 16'h0010);
      pins.pulse(0, 2, 1);
      repeat (3) @(posedge i_clk);
      rd(8'h04, 32'h12);
      wr(8'h00, 16'h0000);
      $display("timer A mode test done");
      wr(8'h50, 16'h001f);
      wr(8'h14, 16'hfffe);
      wr(8'h24, 16'h0000);
      wr(8'h18, 16'h0001);
      wr(8'h28, 16'h0001);
      wr(8'h20, 16'h8002);
      wr(8'h10, 16'h8008);
      a0 = n_adc;
      d0 = n_tb;
      // Idle-stop left clear on the low control, so the pair runs in Idle
      i_idle <= 1'b1;
      run(12, 1'b1);
      i_idle <= 1'b0;
      v = (32'hfffe + 32'(nt)) % 32'h10002;
      rd(8'h14, {16'h0000, v[15:0]});
      rd(8'h24, {16'h0000, v[31:16]});
      check({16'h0000, o_time_base_count0}, {16'h0000, v[15:0]});
      check({16'h0000, o_time_base_count1}, {16'h0000, v[31:16]});
      check(n_tb - d0, nt);
      rd(8'h50, nt >= 4 ? 32'h4 : 32'h0);
      check(n_adc - a0, int'(nt >= 4));
      check(n_dma[1] + n_dma[0] * 2, int'(nt >= 4));
      wr(8'h10, 16'h0000);
      wr(8'h20, 16'h0000);
      $display("joined pair test done");
      wr(8'h50, 16'h001f);
      wr(8'h38, 16'h0001);
      wr(8'h30, 16'h8002);
      a0 = n_adc;
      d0 = n_dma[2];
      pins.pulse(3, 3, 2);
      repeat (3) @(posedge i_clk);
      rd(8'h34, 32'h1);
      rd(8'h50, 32'h8);
      check(n_adc - a0, 0);
      check(n_dma[2] - d0, 1);
      $display("second pair test done");
      report_and_stop();
   end
endmodule : general_purpose_timers_test
